// ### verilog/ident_fault_regs.sv
// Identification and fault-summary registers, reached through decoded accesses.
// Assumes a frame decoder on the same clock gives access strobes and frame events.

module ident_fault_regs
#(
   parameter logic [7:0] SILICON_STEP = 8'h01,  // Arbitrary value
   parameter logic [4:0] PART_CODE    = 5'h05   // Arbitrary value
)
(
   // Clock and reset
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   // Decoded register access
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic [15:0] i_reg_wdata,
   output logic [15:0]      o_reg_rdata,
   output logic             o_reg_rvalid,
   // Frame events
   input  wire logic        i_frame_start,
   input  wire logic        i_checksum_error,
   input  wire logic        i_frame_expired,
   input  wire logic        i_edge_count_error,
   input  wire logic        i_cmd_valid,
   input  wire logic [3:0]  i_cmd_code,
   // Unmasked fault group summaries
   input  wire logic        i_power_pending,
   input  wire logic        i_timebase_pending,
   input  wire logic        i_logic_pending,
   input  wire logic        i_overcurrent_pending,
   // Lock, clock and mode indications
   input  wire logic        i_lock_state,
   input  wire logic        i_clock_state,
   input  wire logic        i_mode_state,
   // Live status word
   output logic [15:0]      o_status
);

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic is_bad_addr(input logic [7:0] addr);
      is_bad_addr = (addr >= sumreg_pkg::ADDR_FIRST_INVALID);
   endfunction

   logic        rd_bad;
   logic        wr_bad;
   logic        wr_status;
   logic [3:0]  restore;
   logic [3:0]  pending;
   logic [3:0]  fault_low;
   logic        restart_low;
   logic [2:0]  indication;
   logic [15:0] id_word;
   logic [15:0] status_word;

   assign rd_bad    = i_reg_rd & is_bad_addr(i_reg_addr);
   assign wr_bad    = i_reg_wr & is_bad_addr(i_reg_addr);
   assign wr_status = i_reg_wr & (i_reg_addr == sumreg_pkg::ADDR_FAULT_SUMMARY);

   assign id_word = {SILICON_STEP, sumreg_pkg::CONVERTER_COUNT, PART_CODE};

   // ---------------------------------------------------------------
   // Reset-occurred flag
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         restart_low <= 1'b0;
      else if (wr_status && i_reg_wdata[sumreg_pkg::BIT_RESTART])
         restart_low <= 1'b1;
   end

   // ---------------------------------------------------------------
   // Aggregated fault flags
   // ---------------------------------------------------------------
   assign pending = {i_power_pending, i_timebase_pending,
                     i_logic_pending, i_overcurrent_pending};

   // Index 3 is bit 14 down to index 0 at bit 11
   genvar g;
   generate
      for (g = 0; g < sumreg_pkg::FAULT_GROUPS; g++)
      begin : gen_fault
         assign restore[g] = wr_status &
                             i_reg_wdata[sumreg_pkg::BIT_OVERCURRENT + g];
         fault_summary_bit u_bit
         (
            .i_clk      (i_clk),
            .i_rst      (i_rst),
            .i_pending  (pending[g]),
            .i_restore  (restore[g]),
            .o_flag_low (fault_low[g])
         );
      end
   endgenerate

   // ---------------------------------------------------------------
   // Per-frame flags
   // ---------------------------------------------------------------
   frame_evt_if evt ();

   assign evt.start     = i_frame_start;
   assign evt.err       = {i_checksum_error, i_frame_expired,
                           i_edge_count_error, rd_bad | wr_bad};
   assign evt.cmd_valid = i_cmd_valid;
   assign evt.cmd_code  = i_cmd_code;
   assign evt.wrote     = i_reg_wr & ~wr_bad;

   frame_status_track u_track
   (
      .i_clk (i_clk),
      .i_rst (i_rst),
      .evt   (evt)
   );

   // ---------------------------------------------------------------
   // Read-only indications
   // ---------------------------------------------------------------
   // Host writes never reach these; they only follow their sources
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         indication <= 3'h0;
      else
         indication <= {i_lock_state, i_clock_state, i_mode_state};
   end

   // ---------------------------------------------------------------
   // Status word and read port
   // ---------------------------------------------------------------
   // Every bit is a flop, so the word and output need no extra stage
   assign status_word = {restart_low, fault_low, evt.shown_err_low,
                         evt.shown_resp, indication};
   assign o_status    = status_word;

   // Unmapped but valid addresses read zero
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_reg_rdata <= 16'h0000;
      else if (i_reg_rd)
      begin
         case (i_reg_addr)
            sumreg_pkg::ADDR_PART_SIGNATURE: o_reg_rdata <= id_word;
            sumreg_pkg::ADDR_FAULT_SUMMARY:  o_reg_rdata <= status_word;
            default:                         o_reg_rdata <= 16'h0000;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_reg_rvalid <= 1'b0;
      else
         o_reg_rvalid <= i_reg_rd;
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   // Helper for the checks only: no frame or command seen since reset yet
   logic frame_seen;

   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         frame_seen <= 1'b0;
      else if (i_frame_start || i_cmd_valid)
         frame_seen <= 1'b1;
   end

   a_id_word_read: assert property (
      i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rvalid && o_reg_rdata ==
         {SILICON_STEP, 3'h4, PART_CODE})
      else $error("identification read wrong");

   a_id_count_field: assert property (
      i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata[7:5] == 3'b100)
      else $error("converter count not 100b");

   a_id_step_code: assert property (
      i_reg_rd && i_reg_addr == 8'h00 |=> o_reg_rdata[15:8] == SILICON_STEP
         && o_reg_rdata[4:0] == PART_CODE)
      else $error("silicon step or part code wrong");

   a_status_reset_value: assert property (
      $fell(i_rst) |-> o_status == 16'h7fc8)
      else $error("status not 7fc8 after reset");

   a_status_read_back: assert property (
      i_reg_rd && i_reg_addr == 8'h01 |=> o_reg_rdata == $past(o_status))
      else $error("status read does not match status");

   a_restart_clear: assert property (
      i_reg_wr && i_reg_addr == 8'h01 && i_reg_wdata[15] |=> o_status[15] [*3])
      else $error("reset flag did not clear to 1");

   a_restart_hold: assert property (
      !o_status[15] && !(i_reg_wr && i_reg_addr == 8'h01) |=> !o_status[15])
      else $error("reset flag rose without a write");

   a_power_low: assert property (
      i_power_pending && i_reg_wr && i_reg_wdata[14] |=> !o_status[14])
      else $error("supply summary restored while pending");

   a_timebase_low: assert property (
      i_timebase_pending ##1 !i_timebase_pending && !i_reg_wr |=> !o_status[13])
      else $error("clock summary rose without a write");

   a_logic_restore: assert property (
      !i_logic_pending && i_reg_wr && i_reg_addr == 8'h01 && i_reg_wdata[12]
         |=> o_status[12])
      else $error("digital summary not restored");

   a_overcurrent_low: assert property (
      i_overcurrent_pending |=> !o_status[11] ##1 (!o_status[11] || !$past(
         i_overcurrent_pending)))
      else $error("overcurrent summary not low");

   a_checksum_shown: assert property (
      i_checksum_error && !i_frame_start ##1 i_frame_start |=> !o_status[10])
      else $error("checksum error not shown");

   a_checksum_cleared: assert property (
      i_frame_start && !i_checksum_error ##1 (!i_checksum_error &&
         !i_frame_start) [*2] ##1 i_frame_start |=> o_status[10])
      else $error("checksum flag not cleared on new frame");

   a_expiry_shown: assert property (
      i_frame_expired && !i_frame_start ##1 i_frame_start |=> !o_status[9])
      else $error("expiry not shown");

   a_edge_shown: assert property (
      i_edge_count_error && !i_frame_start ##1 i_frame_start |=> !o_status[8])
      else $error("edge count error not shown");

   a_bad_addr_shown: assert property (
      i_reg_rd && i_reg_addr == 8'hff && !i_frame_start ##1 i_frame_start
         |=> !o_status[7])
      else $error("bad address not shown");

   a_first_response: assert property (
      $fell(i_rst) |-> o_status[6:3] == 4'h9)
      else $error("first response not 1001b");

   a_null_response: assert property (
      i_frame_start && !i_reg_wr && !i_cmd_valid ##1 (!i_reg_wr && !i_cmd_valid
         && !i_frame_start) [*2] ##1 i_frame_start |=> o_status[6:3] == 4'h1)
      else $error("null response not 0001b");

   a_readonly_kept: assert property (
      i_reg_wr && !i_frame_start && i_lock_state == o_status[2] &&
         i_clock_state == o_status[1] && i_mode_state == o_status[0]
         |=> o_status[10:0] == $past(o_status[10:0]))
      else $error("read-only status bits changed by a write");

   a_rvalid_quiet: assert property (
      !i_reg_rd |=> !o_reg_rvalid)
      else $error("read answer without a read");

   a_bad_read_zero: assert property (
      i_reg_rd && i_reg_addr == 8'hff |=> o_reg_rdata == 16'h0000)
      else $error("bad address read not zero");

   a_power_hold: assert property (
      i_power_pending |=> !o_status[14])
      else $error("supply summary high while pending");

   a_write_response: assert property (
      i_frame_start && !i_cmd_valid ##1 (!i_frame_start && !i_cmd_valid) [*2]
         ##1 i_reg_wr && i_reg_addr == 8'h01 && !i_frame_start && !i_cmd_valid
         ##1 !i_frame_start && !i_cmd_valid ##1 i_frame_start
         |=> o_status[6:3] == 4'h6)
      else $error("write response not 0110b");

   a_first_frame_resp: assert property (
      i_frame_start && !frame_seen && !i_cmd_valid |=> o_status[6:3] == 4'h9)
      else $error("first frame response not 1001b");

   a_frame_flags_hold: assert property (
      !i_frame_start |=> o_status[10:3] == $past(o_status[10:3]))
      else $error("frame flags changed inside a frame");

   a_indication_follow: assert property (
      1'b1 |=> o_status[2:0] == $past({i_lock_state, i_clock_state, i_mode_state}))
      else $error("indications do not follow their sources");

endmodule

// ### verilog/sumreg_pkg.sv
// Constants for the identification and fault-summary register pair.
// Assumes a frame decoder elsewhere supplies decoded register accesses.

package sumreg_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          ADDR_W              = 8;
   localparam int          DATA_W              = 16;
   localparam logic [7:0]  ADDR_PART_SIGNATURE = 8'h00;
   localparam logic [7:0]  ADDR_FAULT_SUMMARY  = 8'h01;
   localparam logic [7:0]  ADDR_FIRST_INVALID  = 8'hff;

   // ---------------------------------------------------------------
   // Identification word layout
   // ---------------------------------------------------------------
   localparam int          SIG_STEP_LSB        = 8;
   localparam int          SIG_COUNT_LSB       = 5;
   localparam int          SIG_CODE_LSB        = 0;
   localparam logic [2:0]  CONVERTER_COUNT     = 3'h4;

   // ---------------------------------------------------------------
   // Summary status word layout
   // ---------------------------------------------------------------
   localparam logic [15:0] STATUS_RESET        = 16'h7fc8;
   localparam int          BIT_RESTART         = 15;
   localparam int          BIT_POWER           = 14;
   localparam int          BIT_TIMEBASE        = 13;
   localparam int          BIT_LOGIC           = 12;
   localparam int          BIT_OVERCURRENT     = 11;
   localparam int          BIT_CHECKSUM        = 10;
   localparam int          BIT_EXPIRY          = 9;
   localparam int          BIT_EDGE            = 8;
   localparam int          BIT_BAD_ADDRESS     = 7;
   localparam int          RESP_LSB            = 3;
   localparam int          BIT_LOCK            = 2;
   localparam int          BIT_CLOCK           = 1;
   localparam int          BIT_MODE            = 0;
   localparam int          FAULT_GROUPS        = 4;

   // ---------------------------------------------------------------
   // Command response codes
   // ---------------------------------------------------------------
   localparam logic [3:0]  RESP_NULL           = 4'h1;
   localparam logic [3:0]  RESP_WRITE          = 4'h6;
   localparam logic [3:0]  RESP_FIRST          = 4'h9;

endpackage

// ### verilog/frame_evt_if.sv
// Frame events from the top to the per-frame flag tracker, and the flags shown.
// Assumes all signals are on the system clock.

interface frame_evt_if;
   logic       start;
   logic [3:0] err;
   logic       cmd_valid;
   logic [3:0] cmd_code;
   logic       wrote;
   logic [3:0] shown_err_low;
   logic [3:0] shown_resp;

   modport src (output start, err, cmd_valid, cmd_code, wrote,
                input  shown_err_low, shown_resp);
   modport dst (input  start, err, cmd_valid, cmd_code, wrote,
                output shown_err_low, shown_resp);
endinterface

// ### verilog/fault_summary_bit.sv
// One active-low aggregated fault flag, restored to 1 by a host write of 1.
// Assumes i_pending is the OR of the unmasked flags of its group, same clock.

module fault_summary_bit
(
   // Clock and reset
   input  wire logic i_clk,
   input  wire logic i_rst,
   // Group state and host restore
   input  wire logic i_pending,
   input  wire logic i_restore,
   // Flag
   output logic      o_flag_low
);

   // A pending group beats a restore in the same cycle
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_flag_low <= 1'b1;
      else if (i_pending)
         o_flag_low <= 1'b0;
      else if (i_restore)
         o_flag_low <= 1'b1;
   end

endmodule

// ### verilog/frame_status_track.sv
// Collects errors and the command of one frame, shows them in the next frame.
// Assumes one start pulse per frame; events in the start cycle belong to it.

module frame_status_track
(
   // Clock and reset
   input  wire logic  i_clk,
   input  wire logic  i_rst,
   // Frame events
   frame_evt_if.dst   evt
);

   logic [3:0] pend_err;
   logic       pend_cmd;
   logic [3:0] pend_code;
   logic       pend_wrote;

   // ---------------------------------------------------------------
   // Current frame collection
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         pend_err <= 4'h0;
      else if (evt.start)
         pend_err <= evt.err;
      else
         pend_err <= pend_err | evt.err;
   end

   always_ff @(posedge i_clk)
   begin
      // Reset leaves the first-frame code pending, so the first frame shows it
      if (i_rst)
      begin
         pend_cmd   <= 1'b1;
         pend_code  <= sumreg_pkg::RESP_FIRST;
         pend_wrote <= 1'b0;
      end
      else
      begin
         if (evt.cmd_valid)
         begin
            pend_cmd  <= 1'b1;
            pend_code <= evt.cmd_code;
         end
         else if (evt.start)
            pend_cmd <= 1'b0;
         pend_wrote <= evt.wrote | (pend_wrote & ~evt.start);
      end
   end

   // ---------------------------------------------------------------
   // Shown in the following frame
   // ---------------------------------------------------------------
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         evt.shown_err_low <= 4'hf;
      else if (evt.start)
         evt.shown_err_low <= ~pend_err;
   end

   // An explicit command code beats the implied write response
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         evt.shown_resp <= sumreg_pkg::RESP_FIRST;
      else if (evt.start)
      begin
         if (pend_cmd)
            evt.shown_resp <= pend_code;
         else if (pend_wrote)
            evt.shown_resp <= sumreg_pkg::RESP_WRITE;
         else
            evt.shown_resp <= sumreg_pkg::RESP_NULL;
      end
   end

endmodule

// ### verif/group_fault_model.sv
// Model of the per-group fault registers behind the summary flags.
// Assumes the bench raises and drops flags on the system clock.

module group_fault_model
(
   // Clock and reset
   input  wire logic       i_clk,
   input  wire logic       i_rst,
   // Flag control, one bit per group
   input  wire logic [3:0] i_raise,
   input  wire logic [3:0] i_drop,
   // Unmasked group summaries
   output logic [3:0]      o_pending
);
   timeunit 1ns;
   timeprecision 1ps;

   // Flags stay set until dropped, like sticky status bits
   always_ff @(posedge i_clk)
   begin
      if (i_rst)
         o_pending <= 4'h0;
      else
         o_pending <= (o_pending | i_raise) & ~i_drop;
   end
endmodule

// ### verif/tb.sv
// Self-checking bench for the identification and fault-summary registers.
// Assumes decoded accesses and frame events driven 1 ns after each rising edge.

module tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic        i_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic        i_reg_wr = 1'b0;
   logic        i_reg_rd = 1'b0;
   logic [7:0]  i_reg_addr = 8'h00;
   logic [15:0] i_reg_wdata = 16'h0000;
   logic [15:0] o_reg_rdata;
   logic        o_reg_rvalid;
   logic        i_frame_start = 1'b0;
   logic [2:0]  err = 3'h0;
   logic        i_cmd_valid = 1'b0;
   logic [3:0]  i_cmd_code = 4'h0;
   logic [2:0]  ind = 3'h0;
   logic [3:0]  raise = 4'h0;
   logic [3:0]  drop = 4'h0;
   logic [3:0]  pending;
   logic [15:0] o_status;
   int          miscompares = 0;
   int          comparisons = 0;

   always #2.5 i_clk = ~i_clk;

   group_fault_model group_fault_model_inst (
      .i_clk(i_clk), .i_rst(i_rst), .i_raise(raise), .i_drop(drop), .o_pending(pending));

   ident_fault_regs #(.SILICON_STEP(8'h3c), .PART_CODE(5'h0a)) ident_fault_regs_inst (
      .i_clk(i_clk), .i_rst(i_rst),
      .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr),
      .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
      .i_frame_start(i_frame_start), .i_checksum_error(err[2]),
      .i_frame_expired(err[1]), .i_edge_count_error(err[0]),
      .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code),
      .i_power_pending(pending[0]), .i_timebase_pending(pending[1]),
      .i_logic_pending(pending[2]), .i_overcurrent_pending(pending[3]),
      .i_lock_state(ind[2]), .i_clock_state(ind[1]), .i_mode_state(ind[0]),
      .o_status(o_status));

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic step(input int n = 1);
      repeat (n) @(posedge i_clk);
      #1;
   endtask

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test;
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic rd(input logic [7:0] addr, input logic [15:0] exp);
      int n;
      i_reg_rd = 1'b1;
      i_reg_addr = addr;
      step();
      i_reg_rd = 1'b0;
      // Bounded wait: a missing answer ends the run
      for (n = 0; n < 4 && o_reg_rvalid !== 1'b1; n++)
         step();
      if (o_reg_rvalid !== 1'b1)
      begin
         miscompares++;
         $display("CHECK FAILED read answer expected 1 seen 0");
         stop_test();
      end
      check("read data", o_reg_rdata, exp);
      step();
      check("read answer end", {15'h0, o_reg_rvalid}, 16'h0000);
   endtask

   task automatic wr(input logic [7:0] addr, input logic [15:0] data);
      i_reg_wr = 1'b1;
      i_reg_addr = addr;
      i_reg_wdata = data;
      step();
      i_reg_wr = 1'b0;
      step();
   endtask

   // Errors belong to the frame that this start opens; they are raised in its
   // last cycle, so back-to-back frames put them right before the next start
   task automatic fstart(input logic [2:0] e);
      i_frame_start = 1'b1;
      step();
      i_frame_start = 1'b0;
      step();
      err = e;
      step();
      err = 3'h0;
   endtask

   task automatic frame_view(input logic [3:0] flags, input logic [3:0] resp);
      check("frame flags", {12'h0, o_status[10:7]}, {12'h0, flags});
      check("response", {12'h0, o_status[6:3]}, {12'h0, resp});
   endtask

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial
   begin
      int k;
      step(3);
      i_rst = 1'b0;
      check("status after reset", o_status, 16'h7fc8);
      fstart(3'h0);
      frame_view(4'hf, 4'h9);
      fstart(3'h0);
      frame_view(4'hf, 4'h1);
      wr(8'h01, 16'h0000);
      fstart(3'h0);
      frame_view(4'hf, 4'h6);
      i_cmd_valid = 1'b1;
      i_cmd_code = 4'h2;
      step();
      i_cmd_valid = 1'b0;
      fstart(3'h0);
      frame_view(4'hf, 4'h2);
      for (k = 0; k < 3; k++)
      begin
         fstart(3'h1 << k);
         fstart(3'h0);
         frame_view(4'hf & ~(4'h2 << k), 4'h1);
         fstart(3'h0);
         frame_view(4'hf, 4'h1);
      end
      // Invalid address: reads as zero, flagged in the next frame only
      rd(8'hff, 16'h0000);
      wr(8'hff, 16'hffff);
      // A bad read in the cycle right before a start
      i_reg_rd = 1'b1;
      i_reg_addr = 8'hff;
      step();
      i_reg_rd = 1'b0;
      fstart(3'h0);
      frame_view(4'he, 4'h1);
      fstart(3'h0);
      frame_view(4'hf, 4'h1);
      rd(8'h00, 16'h3c8a);
      rd(8'h01, 16'h7f88);
      rd(8'h02, 16'h0000);
      wr(8'h00, 16'hffff);
      rd(8'h00, 16'h3c8a);
      wr(8'h01, 16'h7fff);
      check("read-only bits", o_status, 16'h7f88);
      wr(8'h01, 16'h8000);
      check("restart flag", o_status, 16'hff88);
      ind = 3'h5;
      step(2);
      check("indications", {13'h0, o_status[2:0]}, 16'h0005);
      wr(8'h01, 16'h0000);
      check("indications kept", {13'h0, o_status[2:0]}, 16'h0005);
      ind = 3'h0;
      // Each group: drop, refuse restore while pending, restore once clear
      for (k = 0; k < 4; k++)
      begin
         raise = 4'h1 << k;
         step();
         raise = 4'h0;
         step(2);
         check("fault set", {15'h0, o_status[14-k]}, 16'h0000);
         wr(8'h01, 16'h4000 >> k);
         check("restore refused", {15'h0, o_status[14-k]}, 16'h0000);
         drop = 4'h1 << k;
         step();
         drop = 4'h0;
         step(2);
         check("fault held", {15'h0, o_status[14-k]}, 16'h0000);
         wr(8'h01, 16'h4000 >> k);
         check("fault restored", {15'h0, o_status[14-k]}, 16'h0001);
      end
      // Second reset in mid-run brings the restart flag back to 0
      i_rst = 1'b1;
      step(3);
      i_rst = 1'b0;
      check("status after second reset", o_status, 16'h7fc8);
      fstart(3'h0);
      frame_view(4'hf, 4'h9);
      stop_test();
   end
endmodule
